// ==== hw/epa_emulated_phy.sv ====
// Emulated PHY management register bank with deterministic emulated negotiation.
`timescale 1ns/1ps
// Summary of operation
// - negotiate only while enable bit set
// - restart on resets, restart bit, reload
// - restart after loader updates straps
// - complete, then page received, then result
// - common modes are advert AND partner
// - priority 100FD, 100HD, 10FD, 10HD
// - no common mode uses parallel detection
// - advert tech bits reset set, writable
// - advert writes wait for next negotiation
// - partner defaults come from straps
// - strap pin changes alone never rerun negotiation
// - no next page, remote fault, T4
// - success sets partner-able and partner bits
// - MAC local, switch fabric is partner
// - clause 22 bank reports PHY status
// - parallel detect: half duplex, strap speed
// - disabled negotiation forces control speed/duplex
// - chip reset bit clears after 102 us
// - control reset bit self-clears after reset
module epa_emulated_phy #(
	parameter int RESET_CYCLES = epa_pkg::EPA_PHY_RESET_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wr_data_i,
	output logic [15:0] reg_rd_data_o,
	output logic reg_rd_valid_o,
	input wire logic chip_phy_reset_set_i,
	output logic chip_phy_reset_busy_o,
	input wire logic digital_reset_i,
	input wire logic eeprom_reload_i,
	input wire logic eeprom_straps_done_i,
	input wire logic duplex_strap_i,
	input wire logic speed_strap_i,
	output logic link_speed_100_o,
	output logic link_full_duplex_o,
	output logic link_pause_o,
	output logic neg_complete_o,
	output logic loopback_o,
	output logic isolate_o,
	output logic power_down_o,
	output logic collision_test_o,
	output logic phy_in_reset_o
);

	localparam int CW = $clog2(RESET_CYCLES + 1);

	typedef struct packed {
		epa_pkg::epa_state_t state;
		logic pending;
		logic ctrl_reset;
		logic loopback;
		logic forced_speed_bit;
		logic neg_enable_bit;
		logic power_down;
		logic isolate;
		logic neg_restart_bit;
		logic forced_duplex_bit;
		logic coll_test;
		logic [1:0] adv_pause;
		logic [3:0] adv_tech;
		logic [1:0] lp_pause;
		logic [3:0] lp_tech;
		logic lp_neg_able;
		logic page_rx;
		logic neg_complete;
		logic res_speed;
		logic res_duplex;
		logic res_pause;
		logic strap_speed;
		logic strap_duplex;
		logic straps_taken;
		logic chip_rst_busy;
		logic [CW-1:0] rst_cnt;
		logic link_speed;
		logic link_duplex;
		logic link_pause;
		logic [15:0] rd_data;
		logic rd_valid;
	} epa_core_t;

	epa_core_t cur;
	epa_core_t next_cur;
	logic [3:0] partner_tech;
	logic common_any;
	logic best_speed;
	logic best_duplex;
	logic [3:0] best_lp_tech;
	logic [15:0] ctrl_view;
	logic [15:0] abil_adv_view;
	logic [15:0] abil_lp_view;
	logic wr_ctrl;
	logic restart_wr;
	logic neg_trigger;

	// ----------------------------------------------------------------
	// Emulated partner and best common mode
	// ----------------------------------------------------------------
	always_comb begin
		// Partner abilities follow the latched straps only, so strap pin changes alone have no effect.
		partner_tech = {cur.strap_speed & cur.strap_duplex, cur.strap_speed,
			cur.strap_duplex, 1'b1};
	end

	epa_resolver u_resolver (
		.adv_tech_i(cur.adv_tech),
		.partner_tech_i(partner_tech),
		.strap_speed_i(cur.strap_speed),
		.common_any_o(common_any),
		.speed_100_o(best_speed),
		.full_duplex_o(best_duplex),
		.lp_tech_o(best_lp_tech)
	);

	// ----------------------------------------------------------------
	// Register views
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_view = 16'h0000;
		ctrl_view[epa_pkg::EPA_CTRL_RESET] = cur.ctrl_reset;
		ctrl_view[epa_pkg::EPA_CTRL_LOOPBACK] = cur.loopback;
		ctrl_view[epa_pkg::EPA_CTRL_SPEED] = cur.forced_speed_bit;
		ctrl_view[epa_pkg::EPA_CTRL_NEG_EN] = cur.neg_enable_bit;
		ctrl_view[epa_pkg::EPA_CTRL_POWER_DOWN] = cur.power_down;
		ctrl_view[epa_pkg::EPA_CTRL_ISOLATE] = cur.isolate;
		ctrl_view[epa_pkg::EPA_CTRL_RESTART] = cur.neg_restart_bit;
		ctrl_view[epa_pkg::EPA_CTRL_DUPLEX] = cur.forced_duplex_bit;
		ctrl_view[epa_pkg::EPA_CTRL_COLL_TEST] = cur.coll_test;
		// Next page, remote fault and T4 bits are never offered and read zero.
		abil_adv_view = 16'h0000;
		abil_adv_view[epa_pkg::EPA_ABIL_PAUSE_LSB +: 2] = cur.adv_pause;
		abil_adv_view[epa_pkg::EPA_ABIL_TECH_LSB +: 4] = cur.adv_tech;
		abil_adv_view[4:0] = epa_pkg::EPA_ABIL_SELECTOR;
		abil_lp_view = 16'h0000;
		abil_lp_view[epa_pkg::EPA_ABIL_PAUSE_LSB +: 2] = cur.lp_pause;
		abil_lp_view[epa_pkg::EPA_ABIL_TECH_LSB +: 4] = cur.lp_tech;
		abil_lp_view[4:0] = epa_pkg::EPA_ABIL_SELECTOR;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign wr_ctrl = reg_wr_i && cur.state != epa_pkg::EPA_PHY_RESET
		&& reg_addr_i == epa_pkg::EPA_REG_CTRL;
	assign restart_wr = wr_ctrl && reg_wr_data_i[epa_pkg::EPA_CTRL_RESTART];
	// Every event, other than reset_n_i release and the end of a PHY reset, that must start a fresh negotiation run.
	assign neg_trigger = restart_wr || digital_reset_i || eeprom_reload_i
		|| eeprom_straps_done_i
		|| (wr_ctrl && reg_wr_data_i[epa_pkg::EPA_CTRL_NEG_EN] && !cur.neg_enable_bit);

	always_comb begin
		next_cur = cur;
		next_cur.rd_valid = 1'b0;

		// Straps are caught once after reset release and again after a loader update.
		if (!cur.straps_taken || eeprom_straps_done_i) begin
			next_cur.strap_speed = speed_strap_i;
			next_cur.strap_duplex = duplex_strap_i;
			next_cur.straps_taken = 1'b1;
		end
		if (neg_trigger) begin
			next_cur.pending = 1'b1;
		end

		// Register writes from the management side.
		if (reg_wr_i && cur.state != epa_pkg::EPA_PHY_RESET) begin
			if (reg_addr_i == epa_pkg::EPA_REG_CTRL) begin
				next_cur.loopback = reg_wr_data_i[epa_pkg::EPA_CTRL_LOOPBACK];
				next_cur.forced_speed_bit = reg_wr_data_i[epa_pkg::EPA_CTRL_SPEED];
				next_cur.neg_enable_bit = reg_wr_data_i[epa_pkg::EPA_CTRL_NEG_EN];
				next_cur.power_down = reg_wr_data_i[epa_pkg::EPA_CTRL_POWER_DOWN];
				next_cur.isolate = reg_wr_data_i[epa_pkg::EPA_CTRL_ISOLATE];
				next_cur.forced_duplex_bit = reg_wr_data_i[epa_pkg::EPA_CTRL_DUPLEX];
				next_cur.coll_test = reg_wr_data_i[epa_pkg::EPA_CTRL_COLL_TEST];
				if (reg_wr_data_i[epa_pkg::EPA_CTRL_RESTART]) begin
					next_cur.neg_restart_bit = 1'b1;
				end
				if (reg_wr_data_i[epa_pkg::EPA_CTRL_RESET]) begin
					next_cur.ctrl_reset = 1'b1;
				end
			end
			if (reg_addr_i == epa_pkg::EPA_REG_ADV) begin
				// Only the stored advert changes; the result waits for a rerun.
				next_cur.adv_tech = reg_wr_data_i[epa_pkg::EPA_ABIL_TECH_LSB +: 4];
				next_cur.adv_pause = reg_wr_data_i[epa_pkg::EPA_ABIL_PAUSE_LSB +: 2];
			end
		end
		if (chip_phy_reset_set_i) begin
			next_cur.chip_rst_busy = 1'b1;
		end

		case (cur.state)
			epa_pkg::EPA_IDLE: begin
				if (next_cur.ctrl_reset || next_cur.chip_rst_busy) begin
					next_cur.state = epa_pkg::EPA_PHY_RESET;
					next_cur.rst_cnt = '0;
				end else if (cur.pending && cur.straps_taken && cur.neg_enable_bit) begin
					next_cur.state = epa_pkg::EPA_BEGIN;
				end else if (cur.pending && !cur.neg_enable_bit) begin
					next_cur.pending = 1'b0;
					next_cur.neg_restart_bit = 1'b0;
				end
			end
			epa_pkg::EPA_BEGIN: begin
				// A trigger landing in this cycle is kept for the next run.
				next_cur.neg_restart_bit = restart_wr;
				next_cur.pending = neg_trigger;
				next_cur.neg_complete = 1'b0;
				next_cur.page_rx = 1'b0;
				next_cur.lp_neg_able = 1'b0;
				next_cur.state = epa_pkg::EPA_SET_COMPLETE;
			end
			epa_pkg::EPA_SET_COMPLETE: begin
				next_cur.neg_complete = 1'b1;
				next_cur.state = epa_pkg::EPA_SET_PAGE;
			end
			epa_pkg::EPA_SET_PAGE: begin
				next_cur.page_rx = 1'b1;
				next_cur.state = epa_pkg::EPA_RESOLVE;
			end
			epa_pkg::EPA_RESOLVE: begin
				next_cur.res_speed = best_speed;
				next_cur.res_duplex = best_duplex;
				next_cur.lp_neg_able = common_any;
				next_cur.lp_tech = best_lp_tech;
				// The partner mirrors the requested pause abilities only when a common mode exists.
				next_cur.lp_pause = common_any ? cur.adv_pause : 2'h0;
				next_cur.res_pause = best_duplex & cur.adv_pause[0];
				next_cur.state = epa_pkg::EPA_IDLE;
			end
			epa_pkg::EPA_PHY_RESET: begin
				next_cur.rst_cnt = CW'(cur.rst_cnt + 1'b1);
				if (cur.rst_cnt == CW'(RESET_CYCLES - 1)) begin
					// Control and advert registers return to defaults and negotiation restarts.
					// A set landing on the last cycle wins and starts another span.
					next_cur.chip_rst_busy = chip_phy_reset_set_i;
					next_cur.ctrl_reset = 1'b0;
					next_cur.loopback = 1'b0;
					next_cur.forced_speed_bit = epa_pkg::EPA_CTRL_SPEED_RST;
					next_cur.neg_enable_bit = epa_pkg::EPA_CTRL_NEG_EN_RST;
					next_cur.power_down = 1'b0;
					next_cur.isolate = 1'b0;
					next_cur.forced_duplex_bit = epa_pkg::EPA_CTRL_DUPLEX_RST;
					next_cur.coll_test = 1'b0;
					next_cur.adv_tech = epa_pkg::EPA_ADV_TECH_RST;
					next_cur.adv_pause = epa_pkg::EPA_ADV_PAUSE_RST;
					next_cur.pending = 1'b1;
					next_cur.state = epa_pkg::EPA_IDLE;
				end
			end
			default: begin
				next_cur.state = epa_pkg::EPA_IDLE;
			end
		endcase

		// Link result seen by the switch fabric port.
		if (cur.neg_enable_bit) begin
			next_cur.link_speed = cur.res_speed;
			next_cur.link_duplex = cur.res_duplex;
			next_cur.link_pause = cur.res_pause;
		end else begin
			next_cur.link_speed = cur.forced_speed_bit;
			next_cur.link_duplex = cur.forced_duplex_bit;
			next_cur.link_pause = 1'b0;
		end

		// Reads: the MAC is the local side, the fabric is the partner.
		if (reg_rd_i) begin
			next_cur.rd_valid = 1'b1;
			case (reg_addr_i)
				epa_pkg::EPA_REG_CTRL: next_cur.rd_data = ctrl_view;
				epa_pkg::EPA_REG_STATUS: begin
					next_cur.rd_data = epa_pkg::EPA_STAT_FIXED;
					next_cur.rd_data[epa_pkg::EPA_STAT_NEG_DONE] = cur.neg_complete;
				end
				epa_pkg::EPA_REG_ID1: next_cur.rd_data = epa_pkg::EPA_ID1_VALUE;
				epa_pkg::EPA_REG_ID2: next_cur.rd_data = epa_pkg::EPA_ID2_VALUE;
				epa_pkg::EPA_REG_ADV: next_cur.rd_data = abil_adv_view;
				epa_pkg::EPA_REG_LPA: next_cur.rd_data = abil_lp_view;
				epa_pkg::EPA_REG_EXP: begin
					next_cur.rd_data = 16'h0000;
					next_cur.rd_data[epa_pkg::EPA_EXP_PAGE_RX] = cur.page_rx;
					next_cur.rd_data[epa_pkg::EPA_EXP_LP_ABLE] = cur.lp_neg_able;
				end
				default: next_cur.rd_data = 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur <= '0;
			cur.state <= epa_pkg::EPA_IDLE;
			cur.pending <= 1'b1;
			cur.forced_speed_bit <= epa_pkg::EPA_CTRL_SPEED_RST;
			cur.neg_enable_bit <= epa_pkg::EPA_CTRL_NEG_EN_RST;
			cur.forced_duplex_bit <= epa_pkg::EPA_CTRL_DUPLEX_RST;
			cur.adv_tech <= epa_pkg::EPA_ADV_TECH_RST;
			cur.adv_pause <= epa_pkg::EPA_ADV_PAUSE_RST;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rd_data_o = cur.rd_data;
	assign reg_rd_valid_o = cur.rd_valid;
	assign chip_phy_reset_busy_o = cur.chip_rst_busy;
	assign link_speed_100_o = cur.link_speed;
	assign link_full_duplex_o = cur.link_duplex;
	assign link_pause_o = cur.link_pause;
	assign neg_complete_o = cur.neg_complete;
	assign loopback_o = cur.loopback;
	assign isolate_o = cur.isolate;
	assign power_down_o = cur.power_down;
	assign collision_test_o = cur.coll_test;
	assign phy_in_reset_o = (cur.state == epa_pkg::EPA_PHY_RESET);

endmodule : epa_emulated_phy

// ==== hw/epa_resolver.sv ====
// Best common mode selection and parallel detection fallback.
`timescale 1ns/1ps
module epa_resolver (
	input wire logic [3:0] adv_tech_i,
	input wire logic [3:0] partner_tech_i,
	input wire logic strap_speed_i,
	output logic common_any_o,
	output logic speed_100_o,
	output logic full_duplex_o,
	output logic [3:0] lp_tech_o
);

	logic [3:0] common;

	always_comb begin
		common = adv_tech_i & partner_tech_i;
		common_any_o = |common;
		speed_100_o = 1'b0;
		full_duplex_o = 1'b0;
		lp_tech_o = partner_tech_i;
		if (common[epa_pkg::EPA_T_100FD]) begin
			speed_100_o = 1'b1;
			full_duplex_o = 1'b1;
		end else if (common[epa_pkg::EPA_T_100HD]) begin
			speed_100_o = 1'b1;
		end else if (common[epa_pkg::EPA_T_10FD]) begin
			full_duplex_o = 1'b1;
		end else if (common[epa_pkg::EPA_T_10HD]) begin
			speed_100_o = 1'b0;
		end else begin
			// Parallel detection: half duplex at strap speed, one partner bit.
			speed_100_o = strap_speed_i;
			lp_tech_o = strap_speed_i ? 4'h4 : 4'h1;
		end
	end

endmodule : epa_resolver

// ==== include/epa_pkg.sv ====
// Constants, register layout and state encoding of the emulated PHY negotiation block.
package epa_pkg;

	// ----------------------------------------------------------------
	// Clock and reset timing
	// ----------------------------------------------------------------
	localparam int EPA_CLK_PERIOD_NS = 10;
	localparam int EPA_PHY_RESET_TIME_US = 102;
	localparam int EPA_PHY_RESET_CYCLES = (EPA_PHY_RESET_TIME_US * 1000) / EPA_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register indexes of the management bank
	// ----------------------------------------------------------------
	localparam logic [4:0] EPA_REG_CTRL = 5'h00;
	localparam logic [4:0] EPA_REG_STATUS = 5'h01;
	localparam logic [4:0] EPA_REG_ID1 = 5'h02;
	localparam logic [4:0] EPA_REG_ID2 = 5'h03;
	localparam logic [4:0] EPA_REG_ADV = 5'h04;
	localparam logic [4:0] EPA_REG_LPA = 5'h05;
	localparam logic [4:0] EPA_REG_EXP = 5'h06;

	// ----------------------------------------------------------------
	// Basic control field positions
	// ----------------------------------------------------------------
	localparam int EPA_CTRL_RESET = 15;
	localparam int EPA_CTRL_LOOPBACK = 14;
	localparam int EPA_CTRL_SPEED = 13;
	localparam int EPA_CTRL_NEG_EN = 12;
	localparam int EPA_CTRL_POWER_DOWN = 11;
	localparam int EPA_CTRL_ISOLATE = 10;
	localparam int EPA_CTRL_RESTART = 9;
	localparam int EPA_CTRL_DUPLEX = 8;
	localparam int EPA_CTRL_COLL_TEST = 7;
	localparam logic EPA_CTRL_SPEED_RST = 1'h1;
	localparam logic EPA_CTRL_NEG_EN_RST = 1'h1;
	localparam logic EPA_CTRL_DUPLEX_RST = 1'h1;

	// ----------------------------------------------------------------
	// Basic status field positions and fixed content
	// ----------------------------------------------------------------
	localparam int EPA_STAT_NEG_DONE = 5;
	localparam logic [15:0] EPA_STAT_FIXED = 16'h780D;

	// ----------------------------------------------------------------
	// Advertisement and partner ability layout
	// ----------------------------------------------------------------
	localparam int EPA_ABIL_PAUSE_LSB = 10;
	localparam int EPA_ABIL_TECH_LSB = 5;
	localparam logic [4:0] EPA_ABIL_SELECTOR = 5'h01;
	localparam logic [3:0] EPA_ADV_TECH_RST = 4'hF;
	localparam logic [1:0] EPA_ADV_PAUSE_RST = 2'h0;
	// Technology order inside the 4-bit field: 3=100FD, 2=100HD, 1=10FD, 0=10HD.
	localparam int EPA_T_100FD = 3;
	localparam int EPA_T_100HD = 2;
	localparam int EPA_T_10FD = 1;
	localparam int EPA_T_10HD = 0;

	// ----------------------------------------------------------------
	// Expansion field positions
	// ----------------------------------------------------------------
	localparam int EPA_EXP_PAGE_RX = 1;
	localparam int EPA_EXP_LP_ABLE = 0;

	// ----------------------------------------------------------------
	// Identifier values, arbitrary
	// ----------------------------------------------------------------
	localparam logic [15:0] EPA_ID1_VALUE = 16'h1234;
	localparam logic [15:0] EPA_ID2_VALUE = 16'h5670;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		EPA_IDLE,
		EPA_BEGIN,
		EPA_SET_COMPLETE,
		EPA_SET_PAGE,
		EPA_RESOLVE,
		EPA_PHY_RESET
	} epa_state_t;

endpackage : epa_pkg

// ==== testbench/epa_emulated_phy_properties.sv ====
// Concurrent checks on the ports of the emulated PHY negotiation block.
`timescale 1ns/1ps
module epa_emulated_phy_checker #(
	parameter int RESET_CYCLES = epa_pkg::EPA_PHY_RESET_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rd_data_o,
	input wire logic reg_rd_valid_o,
	input wire logic chip_phy_reset_set_i,
	input wire logic chip_phy_reset_busy_o,
	input wire logic digital_reset_i,
	input wire logic eeprom_reload_i,
	input wire logic link_full_duplex_o,
	input wire logic link_pause_o,
	input wire logic neg_complete_o,
	input wire logic phy_in_reset_o
);
	// A negotiation run already in progress may delay the chip reset busy span by one short run.
	localparam int RST_MAX = RESET_CYCLES + 12;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Lengths of the current busy and soft reset spans, in samples.
	int busy_len;
	int rst_len;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_len <= 0;
			rst_len <= 0;
		end else begin
			busy_len <= chip_phy_reset_busy_o ? busy_len + 1 : 0;
			rst_len <= phy_in_reset_o ? rst_len + 1 : 0;
		end
	end
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_settled;
		neg_complete_o && !phy_in_reset_o && !chip_phy_reset_busy_o;
	endsequence
	sequence s_rerun;
		##3 !neg_complete_o ##1 neg_complete_o;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_read_answer: assert property (reg_rd_i |=> reg_rd_valid_o)
		else $error("read without answer");
	a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rd_valid_o)
		else $error("read answer without request");
	a_rd_data_hold: assert property (!reg_rd_valid_o |-> $stable(reg_rd_data_o))
		else $error("read data moved without a read");
	a_busy_cause: assert property ($rose(chip_phy_reset_busy_o) |-> $past(chip_phy_reset_set_i))
		else $error("reset busy rose without a set");
	a_busy_self_clear: assert property (chip_phy_reset_busy_o |-> busy_len < RST_MAX)
		else $error("reset busy did not clear");
	a_reset_span: assert property ($fell(phy_in_reset_o) |-> rst_len == RESET_CYCLES)
		else $error("soft reset span wrong");
	a_reset_bounded: assert property (phy_in_reset_o |-> rst_len < RESET_CYCLES)
		else $error("soft reset did not end");
	a_digital_rerun: assert property (digital_reset_i ##0 s_settled |-> s_rerun)
		else $error("digital reset did not rerun negotiation");
	a_reload_rerun: assert property (eeprom_reload_i ##0 s_settled |-> s_rerun)
		else $error("reload did not rerun negotiation");
	a_pause_duplex: assert property (link_pause_o |-> link_full_duplex_o)
		else $error("pause enabled on half duplex");
endmodule : epa_emulated_phy_checker

bind epa_emulated_phy epa_emulated_phy_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.reg_rd_i(reg_rd_i),
	.reg_rd_data_o(reg_rd_data_o),
	.reg_rd_valid_o(reg_rd_valid_o),
	.chip_phy_reset_set_i(chip_phy_reset_set_i),
	.chip_phy_reset_busy_o(chip_phy_reset_busy_o),
	.digital_reset_i(digital_reset_i),
	.eeprom_reload_i(eeprom_reload_i),
	.link_full_duplex_o(link_full_duplex_o),
	.link_pause_o(link_pause_o),
	.neg_complete_o(neg_complete_o),
	.phy_in_reset_o(phy_in_reset_o)
);

// ==== testbench/epa_emulated_phy_tb.sv ====
// Self-checking testbench of the emulated PHY negotiation block.
`timescale 1ns/1ps
module epa_emulated_phy_tb;
	localparam int RST_CYC = 20;
	logic clk_i = 1'b0, reset_n_i = 1'b0, chip_set = 1'b0, dig = 1'b0, reload = 1'b0;
	logic straps_done = 1'b0, dup_strap = 1'b1, spd_strap = 1'b1;
	logic wr, rd, rd_valid, busy, spd, fd, pause, done, lpb, iso, pdn, col, in_rst;
	logic [4:0] addr;
	logic [15:0] wdata, rdata;
	logic [3:0] advs [5] = '{4'hC, 4'h6, 4'h3, 4'h1, 4'h0};
	int errors = 0, comparisons = 0, n;
	initial forever #5 clk_i = ~clk_i;
	epa_emulated_phy #(.RESET_CYCLES(RST_CYC)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wr_data_i(wdata),
		.reg_rd_data_o(rdata), .reg_rd_valid_o(rd_valid), .chip_phy_reset_set_i(chip_set),
		.chip_phy_reset_busy_o(busy), .digital_reset_i(dig), .eeprom_reload_i(reload),
		.eeprom_straps_done_i(straps_done), .duplex_strap_i(dup_strap),
		.speed_strap_i(spd_strap), .link_speed_100_o(spd), .link_full_duplex_o(fd),
		.link_pause_o(pause), .neg_complete_o(done), .loopback_o(lpb), .isolate_o(iso),
		.power_down_o(pdn), .collision_test_o(col), .phy_in_reset_o(in_rst));
	epa_mac_model mac (.clk_i(clk_i), .rd_data_i(rdata), .rd_valid_i(rd_valid), .wr_o(wr),
		.rd_o(rd), .addr_o(addr), .wr_data_o(wdata));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		mac.read_reg(a, d, ok);
		check({15'h0, ok}, 16'h0001);
		check(d, exp);
	endtask : rd_chk
	task automatic chk_link(input logic [1:0] e);
		check({13'h0, spd, fd, pause}, {13'h0, e, 1'b0});
	endtask : chk_link
	// Best common mode, or parallel detection when nothing is shared.
	function automatic logic [1:0] exp_link(input logic [3:0] c, input logic s);
		if (c[3]) return 2'h3;
		if (c[2]) return 2'h2;
		if (c[1]) return 2'h1;
		if (c[0]) return 2'h0;
		return {s, 1'b0};
	endfunction : exp_link
	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd_chk(5'h00, 16'h3100);
		rd_chk(5'h01, 16'h782D);
		rd_chk(5'h04, 16'h01E1);
		rd_chk(5'h05, 16'h01E1);
		rd_chk(5'h06, 16'h0003);
		rd_chk(5'h02, epa_pkg::EPA_ID1_VALUE);
		rd_chk(5'h07, 16'h0000);
		chk_link(2'h3);
		foreach (advs[i]) begin
			mac.write_reg(5'h04, {7'h00, advs[i], 5'h01});
			mac.write_reg(5'h00, 16'h3300);
			repeat (10) @(posedge clk_i);
			chk_link(exp_link(advs[i], 1'b1));
		end
		rd_chk(5'h05, 16'h0081);
		rd_chk(5'h06, 16'h0002);
		rd_chk(5'h00, 16'h3100);
		mac.write_reg(5'h04, 16'h01E1);
		repeat (10) @(posedge clk_i);
		chk_link(2'h2);
		@(posedge clk_i) dig <= 1'b1;
		@(posedge clk_i) dig <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk_link(2'h3);
		mac.write_reg(5'h04, 16'h0041);
		@(posedge clk_i) reload <= 1'b1;
		@(posedge clk_i) reload <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk_link(2'h1);
		spd_strap <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd_chk(5'h05, 16'h01E1);
		@(posedge clk_i) straps_done <= 1'b1;
		@(posedge clk_i) straps_done <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd_chk(5'h05, 16'h0061);
		chk_link(2'h1);
		mac.write_reg(5'h00, 16'h0000);
		repeat (4) @(posedge clk_i);
		chk_link(2'h0);
		mac.write_reg(5'h00, 16'h6580);
		repeat (4) @(posedge clk_i);
		chk_link(2'h3);
		check({12'h0, lpb, iso, pdn, col}, 16'h000D);
		mac.write_reg(5'h00, 16'h3100);
		repeat (10) @(posedge clk_i);
		chk_link(2'h1);
		@(posedge clk_i) chip_set <= 1'b1;
		@(posedge clk_i) chip_set <= 1'b0;
		@(posedge clk_i);
		check({15'h0, busy}, 16'h0001);
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		check({15'h0, n >= RST_CYC && n <= RST_CYC + 8}, 16'h0001);
		repeat (10) @(posedge clk_i);
		rd_chk(5'h04, 16'h01E1);
		chk_link(2'h1);
		mac.write_reg(5'h00, 16'hB100);
		repeat (3) @(posedge clk_i);
		check({15'h0, in_rst}, 16'h0001);
		repeat (RST_CYC + 20) @(posedge clk_i);
		rd_chk(5'h00, 16'h3100);
		rd_chk(5'h01, 16'h782D);
		mac.write_reg(5'h04, 16'h0441);
		mac.write_reg(5'h00, 16'h3300);
		repeat (10) @(posedge clk_i);
		check({13'h0, spd, fd, pause}, 16'h0003);
		check({15'h0, done}, 16'h0001);
		rd_chk(5'h05, 16'h0461);
		tally_and_finish();
	end
endmodule : epa_emulated_phy_tb

// ==== testbench/epa_mac_model.sv ====
// Model of the MAC that issues management register accesses.
`timescale 1ns/1ps
module epa_mac_model (
	input wire logic clk_i,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic wr_o,
	output logic rd_o,
	output logic [4:0] addr_o,
	output logic [15:0] wr_data_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 5'h00;
		wr_data_o = 16'h0000;
	end
	task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wr_data_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wr_data_o <= ~d;
	endtask : write_reg
	// The answer is sampled one edge after the request is taken.
	task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		ok = rd_valid_i;
		d = rd_data_i;
	endtask : read_reg
endmodule : epa_mac_model
